// ===== design/asurt_pkg.sv
// What this block does
// RULE_01: Receiver checks only the first stop bit for framing error.
// RULE_02: After overrun, the next received character is discarded, not buffered.
// RULE_03: Parity error follows the two parity-mode bits.
// RULE_04: Reading receive error status inserts one wait cycle.
// RULE_05: Software writes transmit buffer only while buffer-full flag is 0.
// RULE_06: Completion pulse raised; software waits for it and shift-busy 0.
// RULE_07: Count clock from internal oscillator is divided; that base is unsupported.
// RULE_08: Prescaler select changes only while power enable is 0.
// RULE_09: Baud divisor rewritten only while tx and rx enables are 0.
// RULE_10: Baud clock is the divisor counter output divided by two.
// RULE_11: Power enable set before tx enable; cleared in reverse order.
// RULE_12: Rx enable rising with pin low starts reception at once.
// RULE_13: Buffer-full sets on write, clears on load; shift-busy sets then.
package asurt_pkg;
  localparam int DATA_W = 8;
  localparam int PSEL_W = 4;
  localparam int DIV_W = 8;
  localparam int OVS = 16;
  localparam logic [DIV_W-1:0] DIV_RST = 8'hFF;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam int ERR_PAR_BIT = 2;
  localparam int ERR_FRM_BIT = 1;
  localparam int ERR_OVR_BIT = 0;
  typedef enum logic [2:0] {ASURT_IDLE, ASURT_START, ASURT_DATA, ASURT_PAR,
    ASURT_STOP} asurt_state_t;
endpackage : asurt_pkg

// ===== design/asurt_stream_if.sv
`timescale 1ns/1ps
interface asurt_stream_if;
  logic valid;
  logic ready;
  logic [asurt_pkg::DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : asurt_stream_if

// ===== design/asurt_buf2.sv
`timescale 1ns/1ps
module asurt_buf2 #(
  parameter int WIDTH = asurt_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  asurt_stream_if.dst in_if,
  asurt_stream_if.src out_if
);
  logic [WIDTH-1:0] mem_reg [2];
  logic wp_reg, rp_reg;
  logic [1:0] cnt_reg;
  wire push = in_if.valid && in_if.ready && ce_in;
  wire pop = out_if.valid && out_if.ready && ce_in;
  assign in_if.ready = cnt_reg != 2'h2;
  assign out_if.valid = cnt_reg != 2'h0;
  assign out_if.data = mem_reg[rp_reg];
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_if.data;
        wp_reg <= ~wp_reg;
      end
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : asurt_buf2

// ===== design/asurt_top.sv
`timescale 1ns/1ps
module asurt_top #(
  parameter int OVS = asurt_pkg::OVS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic unit_power_enable_in,
  input wire logic tx_enable_in,
  input wire logic rx_enable_in,
  input wire logic parity_mode_high_in,
  input wire logic parity_mode_low_in,
  input wire logic two_stop_in,
  input wire logic [asurt_pkg::PSEL_W-1:0] prescaler_select_in,
  input wire logic [asurt_pkg::DIV_W-1:0] baud_divisor_value_in,
  input wire logic transmit_buffer_wr_in,
  input wire logic [asurt_pkg::DATA_W-1:0] transmit_buffer_in,
  input wire logic status_rd_in,
  input wire logic rx_ready_in,
  input wire logic serial_receive_pin_in,
  output logic serial_transmit_pin_out,
  output logic tx_buffer_full_flag_out,
  output logic tx_shift_busy_flag_out,
  output logic tx_done_out,
  output logic [2:0] receive_error_status_out,
  output logic status_wait_out,
  output logic status_ack_out,
  output logic rx_valid_out,
  output logic [asurt_pkg::DATA_W-1:0] receive_buffer_out
);
  asurt_stream_if rx_s ();
  asurt_stream_if rx_o ();
  wire [1:0] pmode = {parity_mode_high_in, parity_mode_low_in};
  // RULE_07 divided count clock
  logic [15:0] pre_reg;
  logic [7:0] div_reg;
  logic half_reg;
  wire pre_tick = (prescaler_select_in == 4'h0) ? 1'b1 :
    (pre_reg[prescaler_select_in - 4'h1] && (pre_reg & ((16'h1 << prescaler_select_in) - 16'h1))
    == ((16'h1 << prescaler_select_in) - 16'h1));
  wire div_hit = pre_tick && (div_reg == baud_divisor_value_in - 8'h1);
  // RULE_10 divide by two
  wire tick = div_hit && half_reg;
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !unit_power_enable_in) begin
      pre_reg <= 16'h0;
      div_reg <= 8'h0;
      half_reg <= 1'b0;
    end else if (ce_in) begin
      pre_reg <= pre_reg + 16'h1;
      if (pre_tick) div_reg <= div_hit ? 8'h0 : div_reg + 8'h1;
      if (div_hit) half_reg <= ~half_reg;
    end
  end
  // Transmitter
  logic [asurt_pkg::DATA_W-1:0] txb_reg, txs_reg;
  logic txbf_reg, txsf_reg, txo_reg, done_reg;
  logic [3:0] tbit_reg, tsub_reg;
  asurt_pkg::asurt_state_t tst_reg;
  wire tx_on = unit_power_enable_in && tx_enable_in;
  wire tx_odd = ^txs_reg;
  wire tpar = (pmode == asurt_pkg::PAR_EVEN) ? tx_odd :
    (pmode == asurt_pkg::PAR_ODD) ? ~tx_odd : 1'b0;
  wire tslot = tick && (tsub_reg == 4'(OVS - 1));
  // RULE_13 load moves flags
  wire tload = txbf_reg && (tst_reg == asurt_pkg::ASURT_IDLE);
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !tx_on) begin
      txbf_reg <= 1'b0;
      txsf_reg <= 1'b0;
      txo_reg <= 1'b1;
      done_reg <= 1'b0;
      tst_reg <= asurt_pkg::ASURT_IDLE;
      tbit_reg <= 4'h0;
      tsub_reg <= 4'h0;
      txb_reg <= 8'h00;
      txs_reg <= 8'h00;
    end else if (ce_in) begin
      done_reg <= 1'b0;
      if (tick) tsub_reg <= tslot ? 4'h0 : tsub_reg + 4'h1;
      // RULE_05 write sets full
      if (transmit_buffer_wr_in) begin
        txb_reg <= transmit_buffer_in;
        txbf_reg <= 1'b1;
      end else if (tload) txbf_reg <= 1'b0;
      unique case (tst_reg)
        asurt_pkg::ASURT_IDLE: if (tload) begin
          txs_reg <= txb_reg;
          txsf_reg <= 1'b1;
          txo_reg <= 1'b0;
          tsub_reg <= 4'h0;
          tst_reg <= asurt_pkg::ASURT_START;
        end
        asurt_pkg::ASURT_START: if (tslot) begin
          txo_reg <= txs_reg[0];
          tbit_reg <= 4'h0;
          tst_reg <= asurt_pkg::ASURT_DATA;
        end
        asurt_pkg::ASURT_DATA: if (tslot) begin
          if (tbit_reg == 4'h7) begin
            txo_reg <= (pmode == asurt_pkg::PAR_NONE) ? 1'b1 : tpar;
            tst_reg <= (pmode == asurt_pkg::PAR_NONE) ? asurt_pkg::ASURT_STOP
              : asurt_pkg::ASURT_PAR;
            tbit_reg <= 4'h0;
          end else begin
            // Rotate so the byte parity survives the shifts
            txs_reg <= {txs_reg[0], txs_reg[7:1]};
            txo_reg <= txs_reg[1];
            tbit_reg <= tbit_reg + 4'h1;
          end
        end
        asurt_pkg::ASURT_PAR: if (tslot) begin
          txo_reg <= 1'b1;
          tst_reg <= asurt_pkg::ASURT_STOP;
        end
        asurt_pkg::ASURT_STOP: if (tslot) begin
          if (two_stop_in && tbit_reg == 4'h0) tbit_reg <= 4'h1;
          else begin
            // RULE_06 completion pulse
            done_reg <= 1'b1;
            txsf_reg <= 1'b0;
            tst_reg <= asurt_pkg::ASURT_IDLE;
          end
        end
      endcase
    end
  end
  // Receiver
  logic [asurt_pkg::DATA_W-1:0] rsh_reg;
  logic [3:0] rbit_reg, rsub_reg;
  logic rpar_reg, ovr_reg, frm_reg, perr_reg, rv_reg, wait_reg, ack_reg;
  logic [2:0] err_reg;
  asurt_pkg::asurt_state_t rst_reg;
  wire rx_on = unit_power_enable_in && rx_enable_in;
  wire rmid = tick && (rsub_reg == 4'(OVS / 2 - 1));
  wire rwrap = rsub_reg == 4'(OVS - 1);
  wire rbit = serial_receive_pin_in;
  wire rodd = ^rsh_reg ^ rbit;
  // RULE_03 parity by mode
  wire pbad = (pmode == asurt_pkg::PAR_EVEN) ? rodd :
    (pmode == asurt_pkg::PAR_ODD) ? ~rodd : 1'b0;
  assign rx_s.valid = rv_reg;
  assign rx_s.data = rsh_reg;
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !rx_on) begin
      rst_reg <= asurt_pkg::ASURT_IDLE;
      rsh_reg <= 8'h00;
      rbit_reg <= 4'h0;
      rsub_reg <= 4'h0;
      rv_reg <= 1'b0;
      ovr_reg <= 1'b0;
      frm_reg <= 1'b0;
      perr_reg <= 1'b0;
      rpar_reg <= 1'b0;
    end else if (ce_in) begin
      rv_reg <= 1'b0;
      // Read clears flags; a set in the same cycle wins
      if (wait_reg) begin
        ovr_reg <= 1'b0;
        frm_reg <= 1'b0;
        perr_reg <= 1'b0;
      end
      if (tick) rsub_reg <= (rst_reg == asurt_pkg::ASURT_IDLE || rwrap) ? 4'h0 : rsub_reg + 4'h1;
      unique case (rst_reg)
        // RULE_12 low pin starts
        asurt_pkg::ASURT_IDLE: if (!rbit) begin
          rsub_reg <= 4'h0;
          rst_reg <= asurt_pkg::ASURT_START;
        end
        asurt_pkg::ASURT_START: if (rmid) rst_reg <= rbit ? asurt_pkg::ASURT_IDLE
          : asurt_pkg::ASURT_DATA;
        asurt_pkg::ASURT_DATA: if (rmid) begin
          rsh_reg <= {rbit, rsh_reg[7:1]};
          rbit_reg <= rbit_reg + 4'h1;
          if (rbit_reg == 4'h7) begin
            rbit_reg <= 4'h0;
            rst_reg <= (pmode == asurt_pkg::PAR_NONE) ? asurt_pkg::ASURT_STOP
              : asurt_pkg::ASURT_PAR;
          end
        end
        asurt_pkg::ASURT_PAR: if (rmid) begin
          rpar_reg <= pbad;
          rst_reg <= asurt_pkg::ASURT_STOP;
        end
        // RULE_01 first stop only
        asurt_pkg::ASURT_STOP: if (rmid) begin
          rst_reg <= asurt_pkg::ASURT_IDLE;
          frm_reg <= !rbit;
          perr_reg <= rpar_reg;
          rpar_reg <= 1'b0;
          // RULE_02 discard after overrun
          if (ovr_reg || !rx_s.ready) ovr_reg <= 1'b1;
          else rv_reg <= 1'b1;
        end
      endcase
    end
  end
  // RULE_04 read wait cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wait_reg <= 1'b0;
      ack_reg <= 1'b0;
      err_reg <= 3'h0;
    end else if (ce_in) begin
      wait_reg <= status_rd_in && !wait_reg && !ack_reg;
      ack_reg <= wait_reg;
      if (wait_reg) err_reg <= {perr_reg, frm_reg, ovr_reg};
    end
  end
  asurt_buf2 #(.WIDTH(asurt_pkg::DATA_W)) u_rxbuf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .in_if(rx_s),
    .out_if(rx_o)
  );
  assign rx_o.ready = rx_ready_in;
  assign rx_valid_out = rx_o.valid;
  assign receive_buffer_out = rx_o.data;
  assign serial_transmit_pin_out = txo_reg;
  assign tx_buffer_full_flag_out = txbf_reg;
  assign tx_shift_busy_flag_out = txsf_reg;
  assign tx_done_out = done_reg;
  assign receive_error_status_out = err_reg;
  assign status_wait_out = status_rd_in && !ack_reg;
  assign status_ack_out = ack_reg;
endmodule : asurt_top

// ===== dv/asurt_top_sva.sv
`timescale 1ns/1ps
module asurt_top_sva (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic unit_power_enable_in,
  input wire logic tx_enable_in,
  input wire logic parity_mode_high_in,
  input wire logic transmit_buffer_wr_in,
  input wire logic status_rd_in,
  input wire logic serial_transmit_pin_out,
  input wire logic tx_buffer_full_flag_out,
  input wire logic tx_shift_busy_flag_out,
  input wire logic tx_done_out,
  input wire logic [2:0] receive_error_status_out,
  input wire logic status_wait_out,
  input wire logic status_ack_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire tx_on = unit_power_enable_in && tx_enable_in;
  sequence s_rd_req;
    $rose(status_rd_in) ##0 status_wait_out;
  endsequence
  sequence s_rd_ans;
    !status_ack_out ##1 status_ack_out;
  endsequence
  a_read_wait: assert property (s_rd_req |-> ##1 s_rd_ans)
    else $error("status read answer not after one wait cycle");
  a_ack_pulse: assert property (status_ack_out |=> !status_ack_out)
    else $error("status ack longer than one cycle");
  a_full_on_write: assert property (tx_on && transmit_buffer_wr_in |=> tx_buffer_full_flag_out)
    else $error("buffer full flag not set by write");
  a_load_busy: assert property (tx_on && $fell(tx_buffer_full_flag_out) |-> tx_shift_busy_flag_out)
    else $error("shift busy not set at load");
  a_start_low: assert property (tx_on && $rose(tx_shift_busy_flag_out) |-> !serial_transmit_pin_out)
    else $error("no start bit at load");
  a_done_pulse: assert property (tx_done_out |=> !tx_done_out)
    else $error("done longer than one cycle");
  a_done_line: assert property (tx_done_out |-> serial_transmit_pin_out)
    else $error("done while line not idle");
  a_parity_off: assert property (status_ack_out && !parity_mode_high_in |-> !receive_error_status_out[2])
    else $error("parity error without checking mode");
endmodule : asurt_top_sva
bind asurt_top asurt_top_sva asurt_top_sva_i (.clk_in(clk_in), .nrst_in(nrst_in),
  .unit_power_enable_in(unit_power_enable_in), .tx_enable_in(tx_enable_in),
  .parity_mode_high_in(parity_mode_high_in), .transmit_buffer_wr_in(transmit_buffer_wr_in),
  .status_rd_in(status_rd_in), .serial_transmit_pin_out(serial_transmit_pin_out),
  .tx_buffer_full_flag_out(tx_buffer_full_flag_out), .tx_done_out(tx_done_out),
  .tx_shift_busy_flag_out(tx_shift_busy_flag_out), .status_wait_out(status_wait_out),
  .receive_error_status_out(receive_error_status_out), .status_ack_out(status_ack_out));

// ===== dv/asurt_peer.sv
`timescale 1ns/1ps
module asurt_peer #(
  parameter int BT = 16
) (
  input wire logic clk_in,
  input wire logic tx_pin_in,
  output logic rx_pin_out
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial rx_pin_out = 1'h1;
  task send_char(input logic [7:0] d, input logic [1:0] pm, input logic bp, input logic bs);
    @(posedge clk_in);
    rx_pin_out <= 1'h0;
    repeat (BT) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      rx_pin_out <= d[i];
      repeat (BT) @(posedge clk_in);
    end
    if (pm != 2'h0) begin
      rx_pin_out <= (pm[1] & (^d ^ ~pm[0])) ^ bp;
      repeat (BT) @(posedge clk_in);
    end
    rx_pin_out <= ~bs;
    repeat (BT) @(posedge clk_in);
    rx_pin_out <= 1'h1;
    repeat (BT) @(posedge clk_in);
  endtask : send_char
  always begin
    @(negedge tx_pin_in);
    repeat (BT / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk_in);
      sh[i] = tx_pin_in;
    end
    got_q.push_back(sh);
    repeat (BT) @(posedge clk_in);
  end
endmodule : asurt_peer

// ===== dv/asurt_top_tb.sv
`timescale 1ns/1ps
module asurt_top_tb;
  localparam int BT = 16;
  logic clk_in = 1'h0, nrst_in = 1'h0, pwr = 1'h0, txe = 1'h0, rxe = 1'h0, two_stop = 1'h0;
  logic wr = 1'h0, rd = 1'h0, rdy = 1'h0, rx_pin, tx_pin, full, busy, done, wt, ack, rv;
  logic [1:0] pm = 2'h0;
  logic [3:0] psel = 4'h0;
  logic [7:0] bdiv = 8'h02;
  logic [2:0] err, e;
  logic [7:0] wdata = 8'h00, rdata, d, q[3];
  logic [31:0] seed = 32'hC7AE;
  int num_errors = 0, samples_checked = 0, n, seen = 0;
  always #25 clk_in = ~clk_in;
  asurt_top #(.OVS(4)) asurt_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'h1),
    .unit_power_enable_in(pwr), .tx_enable_in(txe), .rx_enable_in(rxe),
    .parity_mode_high_in(pm[1]), .parity_mode_low_in(pm[0]), .two_stop_in(two_stop),
    .prescaler_select_in(psel), .baud_divisor_value_in(bdiv), .transmit_buffer_wr_in(wr),
    .transmit_buffer_in(wdata), .status_rd_in(rd), .rx_ready_in(rdy),
    .serial_receive_pin_in(rx_pin), .serial_transmit_pin_out(tx_pin),
    .tx_buffer_full_flag_out(full), .tx_shift_busy_flag_out(busy), .tx_done_out(done),
    .receive_error_status_out(err), .status_wait_out(wt), .status_ack_out(ack),
    .rx_valid_out(rv), .receive_buffer_out(rdata));
  asurt_peer #(.BT(BT)) asurt_peer_i (.clk_in(clk_in), .tx_pin_in(tx_pin), .rx_pin_out(rx_pin));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task stop_test();
    $display("num_errors %0d samples_checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task read_status();
    rd = 1'h1;
    n = 0;
    do begin @(negedge clk_in); n++; end while (ack !== 1'h1 && n < 8);
    e = err;
    if (ack !== 1'h1) num_errors++;
    rd = 1'h0;
    @(negedge clk_in);
  endtask : read_status
  task pop(input logic [7:0] exp);
    chk({7'h00, rv}, 8'h01);
    chk(rdata, exp);
    rdy = 1'h1;
    @(negedge clk_in);
    rdy = 1'h0;
    @(negedge clk_in);
  endtask : pop
  task write_tx(input logic [7:0] v);
    n = 0;
    while (full !== 1'h0 && n < 400) begin @(negedge clk_in); n++; end
    if (n >= 400) num_errors++;
    wdata = v;
    wr = 1'h1;
    @(negedge clk_in);
    wr = 1'h0;
  endtask : write_tx
  initial begin
    repeat (3) @(negedge clk_in);
    nrst_in = 1'h1;
    chk({5'h00, tx_pin, full, busy}, 8'h04);
    pwr = 1'h1;
    @(negedge clk_in);
    txe = 1'h1;
    rxe = 1'h1;
    d = 8'(xs());
    two_stop = d[0];
    write_tx(8'h0F);
    n = 0;
    while (tx_pin !== 1'h0 && n < 200) begin @(negedge clk_in); n++; end
    while (tx_pin !== 1'h1 && n < 400) begin @(negedge clk_in); n++; end
    n = 0;
    while (tx_pin === 1'h1 && n < 200) begin @(negedge clk_in); n++; end
    n = 0;
    while (tx_pin === 1'h0 && n < 200) begin @(negedge clk_in); n++; end
    chk(8'(n), 8'(4 * BT));
    d = 8'(xs());
    write_tx(d);
    n = 0;
    while ((busy | full) !== 1'h0 && n < 2000) begin
      @(negedge clk_in);
      n++;
      if (done === 1'h1) seen++;
    end
    chk(8'(seen > 0), 8'h01);
    chk(8'(asurt_peer_i.got_q.size()), 8'h02);
    chk(asurt_peer_i.got_q[0], 8'h0F);
    chk(asurt_peer_i.got_q[1], d);
    for (int m = 0; m < 4; m++) begin
      txe = 1'h0;
      rxe = 1'h0;
      @(negedge clk_in);
      pm = 2'(m);
      two_stop = pm[0];
      if (m == 2) begin
        pwr = 1'h0;
        psel = 4'h1;
        bdiv = 8'h01;
        @(negedge clk_in);
        pwr = 1'h1;
      end
      @(negedge clk_in);
      txe = 1'h1;
      rxe = 1'h1;
      d = 8'(xs());
      asurt_peer_i.send_char(d, pm, 1'h1, m == 0);
      @(negedge clk_in);
      read_status();
      chk({5'h00, e}, {5'h00, pm[1], m == 0, 1'h0});
      if (m != 0) pop(d);
      else begin
        rdy = 1'h1;
        @(negedge clk_in);
        rdy = 1'h0;
      end
    end
    for (int k = 0; k < 3; k++) begin
      q[k] = 8'(xs());
      asurt_peer_i.send_char(q[k], pm, 1'h0, 1'h0);
    end
    @(negedge clk_in);
    read_status();
    chk({5'h00, e}, 8'h01);
    pop(q[0]);
    pop(q[1]);
    chk({7'h00, rv}, 8'h00);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    stop_test();
  end
endmodule : asurt_top_tb
